//--- core/sleep_gate_pkg.sv
// Types shared by the sleep gating block
package sleep_gate_pkg;

   typedef enum logic [1:0] {
      MODE_RUN   = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_DEEP  = 2'b10
   } power_mode_t;

   typedef logic [31:0] gate_word_t;

endpackage

//--- core/sleep_gate_regs.svh
// Register offsets, field positions and reset values of the sleep gating block
`ifndef SLEEP_GATE_REGS_SVH
`define SLEEP_GATE_REGS_SVH

`define GATE_ADDR_W        12
`define GATE_DATA_W        32
`define GATE_NUM_UNITS     13

`define SLEEP_GATE_OFS     12'h114
`define GATE_CTRL_OFS      12'h200
`define GATE_STAT_OFS      12'h204
`define GATE_FAULT_OFS     12'h208

`define SLEEP_GATE_RST     32'h0000_0000
`define SLEEP_GATE_WMASK   32'h030f_5037
`define GATE_CTRL_RST      32'h0000_0000
`define GATE_FAULT_RST     32'h0000_0000
`define GATE_CTRL_WMASK    32'h0000_0001
`define AUTO_GATE_BIT      0

`define ASYNC0_BIT         0
`define ASYNC1_BIT         1
`define ASYNC2_BIT         2
`define SYNC0_BIT          4
`define SYNC1_BIT          5
`define TWO_WIRE0_BIT      12
`define TWO_WIRE1_BIT      14
`define GP_CNT0_BIT        16
`define GP_CNT1_BIT        17
`define GP_CNT2_BIT        18
`define GP_CNT3_BIT        19
`define ANA_CMP0_BIT       24
`define ANA_CMP1_BIT       25

`endif

//--- core/sleep_mode_clock_gating.sv
// Sleep-mode peripheral clock gating register and per-unit clock enables
//
// Overview of operation
// - One 32-bit sleep gating register, 0x114
// - Set bit clocks unit, clear bit stops
// - Access to unclocked unit answers bus fault
// - All enables read zero after reset
// - Bits 25, 24 gate analog comparators
// - Bits 19..16 gate general counters 3..0
// - Bits 14, 12 gate two-wire ports
// - Bits 5, 4 gate synchronous serial
// - Bits 2..0 gate asynchronous serial ports
// - Reserved bits read zero, ignore writes
// - Used only in sleep with auto gating
`timescale 1ns/1ps
`include "sleep_gate_regs.svh"
module sleep_mode_clock_gating
   import sleep_gate_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Register port
   input  wire logic [11:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   output logic      [31:0] rdata_o,
   // Power state and companion gating words
   input  wire logic        sleep_i,
   input  wire logic        deep_sleep_i,
   input  wire logic [31:0] run_enables_i,
   input  wire logic [31:0] deep_enables_i,
   // Bus accesses aimed at each unit
   input  wire logic        async0_access_i,
   input  wire logic        async1_access_i,
   input  wire logic        async2_access_i,
   input  wire logic        sync0_access_i,
   input  wire logic        sync1_access_i,
   input  wire logic        two_wire0_access_i,
   input  wire logic        two_wire1_access_i,
   input  wire logic        gp_cnt0_access_i,
   input  wire logic        gp_cnt1_access_i,
   input  wire logic        gp_cnt2_access_i,
   input  wire logic        gp_cnt3_access_i,
   input  wire logic        ana_cmp0_access_i,
   input  wire logic        ana_cmp1_access_i,
   // Clock enables toward each unit
   output logic             async_serial0_gate_o,
   output logic             async_serial1_gate_o,
   output logic             async_serial2_gate_o,
   output logic             sync_serial0_gate_o,
   output logic             sync_serial1_gate_o,
   output logic             two_wire_port0_gate_o,
   output logic             two_wire_port1_gate_o,
   output logic             gp_counter0_gate_o,
   output logic             gp_counter1_gate_o,
   output logic             gp_counter2_gate_o,
   output logic             gp_counter3_gate_o,
   output logic             analog_cmp0_gate_o,
   output logic             analog_cmp1_gate_o,
   // Bus fault answers, one cycle after the access
   output logic             async0_fault_o,
   output logic             async1_fault_o,
   output logic             async2_fault_o,
   output logic             sync0_fault_o,
   output logic             sync1_fault_o,
   output logic             two_wire0_fault_o,
   output logic             two_wire1_fault_o,
   output logic             gp_cnt0_fault_o,
   output logic             gp_cnt1_fault_o,
   output logic             gp_cnt2_fault_o,
   output logic             gp_cnt3_fault_o,
   output logic             ana_cmp0_fault_o,
   output logic             ana_cmp1_fault_o,
   // Plain sleep flag, low in run and deep sleep
   output logic             in_sleep_o
);

   localparam int NUM_UNITS = `GATE_NUM_UNITS;

   // Bit position of each unit inside a gating word
   function automatic int unit_bit(input int idx);
      int pos;
      pos = 0;
      case (idx)
         0:       pos = `ASYNC0_BIT;
         1:       pos = `ASYNC1_BIT;
         2:       pos = `ASYNC2_BIT;
         3:       pos = `SYNC0_BIT;
         4:       pos = `SYNC1_BIT;
         5:       pos = `TWO_WIRE0_BIT;
         6:       pos = `TWO_WIRE1_BIT;
         7:       pos = `GP_CNT0_BIT;
         8:       pos = `GP_CNT1_BIT;
         9:       pos = `GP_CNT2_BIT;
         10:      pos = `GP_CNT3_BIT;
         11:      pos = `ANA_CMP0_BIT;
         12:      pos = `ANA_CMP1_BIT;
         default: pos = 0;
      endcase
      return pos;
   endfunction

   // Register state
   gate_word_t    sleep_gate_q;
   gate_word_t    sleep_gate_d;
   gate_word_t    ctrl_q;
   gate_word_t    ctrl_d;
   gate_word_t    fault_log_q;
   gate_word_t    fault_log_d;
   gate_word_t    rdata_q;
   gate_word_t    rdata_d;
   power_mode_t   mode_q;
   power_mode_t   mode_d;

   // Unit-side vectors
   gate_word_t                 eff_enables;
   gate_word_t                 gate_word;
   gate_word_t                 fault_word;
   logic       [NUM_UNITS-1:0] unit_access;
   logic       [NUM_UNITS-1:0] unit_enable;
   logic       [NUM_UNITS-1:0] unit_clk_en;
   logic       [NUM_UNITS-1:0] unit_fault;

   logic auto_gate;
   logic hit_sleep;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_fault;

   assign auto_gate = ctrl_q[`AUTO_GATE_BIT];
   assign hit_sleep = (addr_i == `SLEEP_GATE_OFS);
   assign hit_ctrl  = (addr_i == `GATE_CTRL_OFS);
   assign hit_stat  = (addr_i == `GATE_STAT_OFS);
   assign hit_fault = (addr_i == `GATE_FAULT_OFS);

   // Power mode; deep sleep outranks plain sleep
   always_comb begin
      if (deep_sleep_i) begin
         mode_d = MODE_DEEP;
      end else if (sleep_i) begin
         mode_d = MODE_SLEEP;
      end else begin
         mode_d = MODE_RUN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= MODE_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Pick the gating word that governs the present mode. Without auto
   // gating the run word stays in force through every sleep state.
   always_comb begin
      case (mode_q)
         MODE_RUN: begin
            eff_enables = run_enables_i;
         end
         MODE_SLEEP: begin
            eff_enables = auto_gate ? sleep_gate_q : run_enables_i;
         end
         MODE_DEEP: begin
            eff_enables = auto_gate ? deep_enables_i : run_enables_i;
         end
         default: begin
            eff_enables = run_enables_i;
         end
      endcase
   end

   // Register writes; reserved bits are masked away
   always_comb begin
      sleep_gate_d = sleep_gate_q;
      ctrl_d       = ctrl_q;
      if (we_i && hit_sleep) begin
         sleep_gate_d = wdata_i & `SLEEP_GATE_WMASK;
      end
      if (we_i && hit_ctrl) begin
         ctrl_d = wdata_i & `GATE_CTRL_WMASK;
      end
   end

   // Fault log: write one to clear, a new fault in the same cycle wins
   always_comb begin
      fault_log_d = fault_log_q;
      if (we_i && hit_fault) begin
         fault_log_d = fault_log_q & ~wdata_i;
      end
      fault_log_d = fault_log_d | fault_word;
   end

   // Read data stands for the one cycle after the read strobe
   always_comb begin
      rdata_d = '0;
      if (re_i) begin
         if (hit_sleep) begin
            rdata_d = sleep_gate_q & `SLEEP_GATE_WMASK;
         end else if (hit_ctrl) begin
            rdata_d = ctrl_q;
         end else if (hit_stat) begin
            rdata_d = gate_word;
         end else if (hit_fault) begin
            rdata_d = fault_log_q;
         end else begin
            rdata_d = '0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleep_gate_q <= `SLEEP_GATE_RST;
         ctrl_q       <= `GATE_CTRL_RST;
         fault_log_q  <= `GATE_FAULT_RST;
         rdata_q      <= '0;
      end else begin
         sleep_gate_q <= sleep_gate_d;
         ctrl_q       <= ctrl_d;
         fault_log_q  <= fault_log_d;
         rdata_q      <= rdata_d;
      end
   end

   assign rdata_o = rdata_q;

   // Gather the per-unit accesses in bit order of the unit list
   assign unit_access[0]  = async0_access_i;
   assign unit_access[1]  = async1_access_i;
   assign unit_access[2]  = async2_access_i;
   assign unit_access[3]  = sync0_access_i;
   assign unit_access[4]  = sync1_access_i;
   assign unit_access[5]  = two_wire0_access_i;
   assign unit_access[6]  = two_wire1_access_i;
   assign unit_access[7]  = gp_cnt0_access_i;
   assign unit_access[8]  = gp_cnt1_access_i;
   assign unit_access[9]  = gp_cnt2_access_i;
   assign unit_access[10] = gp_cnt3_access_i;
   assign unit_access[11] = ana_cmp0_access_i;
   assign unit_access[12] = ana_cmp1_access_i;

   // One gate cell per unit
   for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
      assign unit_enable[g] = eff_enables[unit_bit(g)];
      unit_gate_cell u_cell (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .enable_i (unit_enable[g]),
         .access_i (unit_access[g]),
         .clk_en_o (unit_clk_en[g]),
         .fault_o  (unit_fault[g])
      );
   end

   // Live enables and faults laid out in register bit positions
   always_comb begin
      gate_word  = '0;
      fault_word = '0;
      for (int i = 0; i < NUM_UNITS; i++) begin
         gate_word[unit_bit(i)]  = unit_clk_en[i];
         fault_word[unit_bit(i)] = unit_fault[i];
      end
   end

   assign async_serial0_gate_o  = unit_clk_en[0];
   assign async_serial1_gate_o  = unit_clk_en[1];
   assign async_serial2_gate_o  = unit_clk_en[2];
   assign sync_serial0_gate_o   = unit_clk_en[3];
   assign sync_serial1_gate_o   = unit_clk_en[4];
   assign two_wire_port0_gate_o = unit_clk_en[5];
   assign two_wire_port1_gate_o = unit_clk_en[6];
   assign gp_counter0_gate_o    = unit_clk_en[7];
   assign gp_counter1_gate_o    = unit_clk_en[8];
   assign gp_counter2_gate_o    = unit_clk_en[9];
   assign gp_counter3_gate_o    = unit_clk_en[10];
   assign analog_cmp0_gate_o    = unit_clk_en[11];
   assign analog_cmp1_gate_o    = unit_clk_en[12];

   assign async0_fault_o    = unit_fault[0];
   assign async1_fault_o    = unit_fault[1];
   assign async2_fault_o    = unit_fault[2];
   assign sync0_fault_o     = unit_fault[3];
   assign sync1_fault_o     = unit_fault[4];
   assign two_wire0_fault_o = unit_fault[5];
   assign two_wire1_fault_o = unit_fault[6];
   assign gp_cnt0_fault_o   = unit_fault[7];
   assign gp_cnt1_fault_o   = unit_fault[8];
   assign gp_cnt2_fault_o   = unit_fault[9];
   assign gp_cnt3_fault_o   = unit_fault[10];
   assign ana_cmp0_fault_o  = unit_fault[11];
   assign ana_cmp1_fault_o  = unit_fault[12];

   assign in_sleep_o = (mode_q == MODE_SLEEP);

endmodule

//--- core/unit_gate_cell.sv
// One unit's clock enable and its access fault flag
`timescale 1ns/1ps
module unit_gate_cell (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Requested enable and bus access to the unit
   input  wire logic enable_i,
   input  wire logic access_i,
   // Clock enable and fault answer
   output logic      clk_en_o,
   output logic      fault_o
);

   logic clk_en_q;
   logic clk_en_d;
   logic fault_q;
   logic fault_d;

   // Enable changes only on a rising edge, so the unit never sees a
   // shortened clock pulse
   always_comb begin
      clk_en_d = enable_i;
      fault_d  = access_i & ~clk_en_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_en_q <= 1'b0;
         fault_q  <= 1'b0;
      end else begin
         clk_en_q <= clk_en_d;
         fault_q  <= fault_d;
      end
   end

   assign clk_en_o = clk_en_q;
   assign fault_o  = fault_q;

endmodule

//--- sim/sleep_gate_properties.sv
// Port-level checks for the sleep gating block
`timescale 1ns/1ps
module sleep_gate_properties (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Register port
   input wire logic [11:0] addr_i,
   input wire logic        re_i,
   input wire logic [31:0] rdata_o,
   // Mode and run word
   input wire logic        sleep_i,
   input wire logic        deep_sleep_i,
   input wire logic [31:0] run_enables_i,
   input wire logic        in_sleep_o,
   // Two sample units
   input wire logic        async0_access_i,
   input wire logic        async_serial0_gate_o,
   input wire logic        async0_fault_o,
   input wire logic        ana_cmp1_access_i,
   input wire logic        analog_cmp1_gate_o,
   input wire logic        ana_cmp1_fault_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   idle_rdata_a: assert property (
      !$past(re_i) |-> rdata_o == 32'h0) else $error("rdata not idle");
   unmapped_zero_a: assert property (
      re_i && addr_i == 12'h118 |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (
      re_i |=> (rdata_o & ~32'h030f_5037) == 32'h0)
      else $error("reserved bits read set");
   reset_clear_a: assert property (
      $fell(rst_i) |-> !async_serial0_gate_o && !analog_cmp1_gate_o
      && !in_sleep_o) else $error("gate on after reset");
   fault_cause_a: assert property (
      async0_fault_o |-> $past(async0_access_i && !async_serial0_gate_o))
      else $error("fault without gated access");
   cmp_fault_a: assert property (
      ana_cmp1_access_i && !analog_cmp1_gate_o |=> ana_cmp1_fault_o)
      else $error("gated access not faulted");
   run_follow_a: assert property (
      (!sleep_i && !deep_sleep_i)[*2] ##0 $stable(run_enables_i) |=>
      async_serial0_gate_o == $past(run_enables_i[0]))
      else $error("run gate wrong");
   mode_track_a: assert property (
      in_sleep_o == $past(sleep_i && !deep_sleep_i))
      else $error("sleep flag wrong");
endmodule

bind sleep_mode_clock_gating sleep_gate_properties u_props (
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .re_i(re_i),
   .rdata_o(rdata_o), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
   .run_enables_i(run_enables_i), .in_sleep_o(in_sleep_o),
   .async0_access_i(async0_access_i),
   .async_serial0_gate_o(async_serial0_gate_o),
   .async0_fault_o(async0_fault_o), .ana_cmp1_access_i(ana_cmp1_access_i),
   .analog_cmp1_gate_o(analog_cmp1_gate_o),
   .ana_cmp1_fault_o(ana_cmp1_fault_o));

//--- sim/testbench.sv
// Self-checking bench for the sleep gating block
`timescale 1ns/1ps
module testbench;
   import sleep_gate_pkg::*;
   localparam gate_word_t MASK = 32'h030f_5037;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [11:0] addr_i = 12'h0;
   gate_word_t  wdata_i = '0, run_w = '0, deep_w = '0, acc = '0, sw, ew;
   logic        we_i = 1'b0, re_i = 1'b0, sleep_i = 1'b0, deep_i = 1'b0;
   logic        in_sleep_o, re_q = 1'b0, auto_on;
   wire  [31:0] rdata_o, gate, fault;
   gate_word_t  exp_q[$];
   int          fail_count = 0, check_count = 0, cyc = 0;

   sleep_mode_clock_gating u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
      .deep_sleep_i(deep_i), .run_enables_i(run_w),
      .deep_enables_i(deep_w), .in_sleep_o(in_sleep_o),
      .async0_access_i(acc[0]), .async1_access_i(acc[1]),
      .async2_access_i(acc[2]), .sync0_access_i(acc[4]),
      .sync1_access_i(acc[5]), .two_wire0_access_i(acc[12]),
      .two_wire1_access_i(acc[14]), .gp_cnt0_access_i(acc[16]),
      .gp_cnt1_access_i(acc[17]), .gp_cnt2_access_i(acc[18]),
      .gp_cnt3_access_i(acc[19]), .ana_cmp0_access_i(acc[24]),
      .ana_cmp1_access_i(acc[25]),
      .async_serial0_gate_o(gate[0]), .async_serial1_gate_o(gate[1]),
      .async_serial2_gate_o(gate[2]), .sync_serial0_gate_o(gate[4]),
      .sync_serial1_gate_o(gate[5]), .two_wire_port0_gate_o(gate[12]),
      .two_wire_port1_gate_o(gate[14]), .gp_counter0_gate_o(gate[16]),
      .gp_counter1_gate_o(gate[17]), .gp_counter2_gate_o(gate[18]),
      .gp_counter3_gate_o(gate[19]), .analog_cmp0_gate_o(gate[24]),
      .analog_cmp1_gate_o(gate[25]),
      .async0_fault_o(fault[0]), .async1_fault_o(fault[1]),
      .async2_fault_o(fault[2]), .sync0_fault_o(fault[4]),
      .sync1_fault_o(fault[5]), .two_wire0_fault_o(fault[12]),
      .two_wire1_fault_o(fault[14]), .gp_cnt0_fault_o(fault[16]),
      .gp_cnt1_fault_o(fault[17]), .gp_cnt2_fault_o(fault[18]),
      .gp_cnt3_fault_o(fault[19]), .ana_cmp0_fault_o(fault[24]),
      .ana_cmp1_fault_o(fault[25]));

   always #2 clk_i = ~clk_i;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(gate_word_t got, gate_word_t exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_i) re_q <= re_i;
   always @(negedge clk_i) if (re_q) chk(rdata_o, exp_q.pop_front());

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wr(logic [11:0] a, gate_word_t d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask

   task automatic rd(logic [11:0] a, gate_word_t e);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_i);
      re_i <= 1'b0;
   endtask

   // Mode and word reach the gates two edges late; three leaves margin
   task automatic settle(gate_word_t e);
      repeat (3) @(posedge clk_i);
      #1 chk(gate & MASK, e);
      rd(12'h204, e);
   endtask

   // Touch every unit at once; only the stopped ones may fault
   task automatic poke(gate_word_t e);
      @(posedge clk_i);
      acc <= MASK;
      @(posedge clk_i);
      acc <= '0;
      #1 chk(fault & MASK, ~e & MASK);
      rd(12'h208, ~e & MASK);
      wr(12'h208, MASK);
      rd(12'h208, '0);
   endtask

   initial begin
      void'($urandom(10));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(12'h114, '0);
      settle('0);
      poke('0);
      wr(12'h114, '1);
      rd(12'h114, MASK);
      rd(12'h118, '0);
      $display("reset and map test done");
      for (int i = 0; i < 8; i++) begin
         sw = $urandom;
         run_w <= $urandom;
         deep_w <= $urandom;
         // Early passes scribble on reserved bits, later ones write them as zero
         wr(12'h114, i < 4 ? sw : sw & MASK);
         rd(12'h114, sw & MASK);
         // Deep sleep without auto gating must fall back to the run word
         auto_on = i % 4 != 3 && i != 6;
         wr(12'h200, {31'h0, auto_on});
         rd(12'h200, {31'h0, auto_on});
         sleep_i <= i % 2 == 1;
         deep_i <= i % 4 == 2;
         ew = !auto_on ? run_w : i % 4 == 1 ? sw
            : i % 4 == 2 ? deep_w : run_w;
         settle(ew & MASK);
         chk({31'h0, in_sleep_o}, {31'h0, i % 2 == 1});
         poke(ew & MASK);
         $display("mode test %0d done", i);
      end
      // The bench clears the companion words before reset, so the gates go idle
      sleep_i <= 1'b0;
      run_w <= '0;
      deep_w <= '0;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(12'h114, '0);
      settle('0);
      $display("second reset test done");
      repeat (3) @(posedge clk_i);
      wrap_up();
   end
endmodule
